// ===== inc/port_err_pkg.sv
/*
  Constants and state types for the port error and time-out register bank.
  Assumes a 100 MHz core clock and a 12-bit APB byte address.
*/
package port_err_pkg;

  // ---------------------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [11:0] PERR_STATUS_ADDR = 12'h744;
  localparam logic [11:0] REPORT_CTL_ADDR  = 12'h748;
  localparam logic [11:0] COUNT_ADDR       = 12'h74C;
  localparam logic [11:0] TMO_CTL_ADDR     = 12'h750;
  localparam logic [11:0] TMO_STATUS_ADDR  = 12'h754;
  localparam logic [11:0] INT_MASK_ADDR    = 12'h7F0;
  localparam logic [11:0] INT_STATUS_ADDR  = 12'h7F4;

  // ---------------------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------------------
  localparam int unsigned REPORT_SEL_LSB = 0;
  localparam int unsigned COUNT_LSB      = 0;
  localparam int unsigned TMO_ENABLE_BIT = 0;
  localparam int unsigned TMO_FLAG_LSB   = 0;
  localparam int unsigned PERR_FLAG_BIT  = 0;
  localparam int unsigned INT_PERR_BIT   = 0;
  localparam int unsigned INT_TMO_LSB    = 1;
  localparam int unsigned NUM_QUEUES     = 4;
  localparam int unsigned INT_BITS       = 5;

  // ---------------------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------------------
  localparam logic [1:0] REPORT_SEL_RESET = 2'h2;
  localparam logic [1:0] REPORT_NONE      = 2'h0;
  localparam logic [1:0] MSG_COR          = 2'h1;
  localparam logic [1:0] MSG_NONFATAL     = 2'h2;
  localparam logic [1:0] MSG_FATAL        = 2'h3;
  localparam logic [7:0] COUNT_RESET      = 8'h00;
  localparam logic [7:0] COUNT_MAX        = 8'hFF;
  localparam logic       TMO_ENABLE_RESET = 1'b1;

  // ---------------------------------------------------------------------------
  // Time-out limit
  // ---------------------------------------------------------------------------
  localparam int unsigned TIMEOUT_MS     = 50;
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned AGE_W          = 23;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  localparam int unsigned ACC_READY_BIT = 1;

  typedef enum logic [1:0] {
    ACC_WAIT  = 2'b01,
    ACC_READY = 2'b10
  } acc_phase_type;

  typedef struct packed {
    acc_phase_type        phase;
    logic [31:0]          prdata;
    logic                 pslverr;
    logic [1:0]           report_sel;
    logic [7:0]           count;
    logic                 tmo_enable;
    logic [3:0]           tmo_flag;
    logic                 perr_flag;
    logic [INT_BITS-1:0]  int_status;
    logic [INT_BITS-1:0]  int_mask;
    logic                 irq;
    logic                 msg_valid;
    logic [1:0]           msg_type;
  } core_state_type;

  typedef struct packed {
    logic [NUM_QUEUES-1:0][AGE_W-1:0] age;
    logic [NUM_QUEUES-1:0]            discard;
  } ager_state_type;

endpackage

// ===== inc/age_if.sv
/*
  Signals between the register bank and the queue age tracker.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface age_if;
  logic       enable;
  logic [3:0] head_valid;
  logic [3:0] head_taken;
  logic [3:0] discard;

  modport core (
    output enable,
    output head_valid,
    output head_taken,
    input  discard
  );

  modport ager (
    input  enable,
    input  head_valid,
    input  head_taken,
    output discard
  );
endinterface

`default_nettype wire

// ===== hw/queue_age_tracker.sv
/*
  Ages the packet at the head of each of the four input queues and asks
  for its discard once it has waited longer than the limit.
  Assumes head_valid and head_taken come from queue logic on pclk.
*/
`timescale 1ns/10ps
`default_nettype none

module queue_age_tracker #(
  parameter int unsigned LIMIT_CYCLES = port_err_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Queue side
  age_if.ager      aif
);

  localparam logic [port_err_pkg::AGE_W-1:0] LIMIT = LIMIT_CYCLES[port_err_pkg::AGE_W-1:0];

  port_err_pkg::ager_state_type st_q;
  port_err_pkg::ager_state_type st_d;

  // ---------------------------------------------------------------------------
  // Age counters
  // ---------------------------------------------------------------------------
  // Only the head packet is aged; a packet behind a fresh head waits longer
  // than the limit before it can be dropped, traded for one counter a queue.
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < 4; i++) begin
      st_d.discard[i] = 1'b0;
      if (!aif.enable || !aif.head_valid[i] || aif.head_taken[i] || st_q.discard[i]) begin
        st_d.age[i] = '0;
      end else if (st_q.age[i] == LIMIT) begin
        st_d.discard[i] = 1'b1;                                     // [R7] [R13]
        st_d.age[i]     = '0;
      end else begin
        st_d.age[i] = st_q.age[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign aif.discard = st_q.discard;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  discard_needs_enable_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    (|st_q.discard) |-> $past(aif.enable))
    else $error("discard raised while time-outs disabled");

  discard_at_limit_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    st_q.discard[0] |-> ($past(st_q.age[0]) == LIMIT) && $past(aif.head_valid[0]))
    else $error("posted queue discard before the age limit");

endmodule

`default_nettype wire

// ===== hw/port_err_regs.sv
/*
  Port error and time-out register bank: parity error reporting and
  counting, time-out discard enable, time-out status flags and interrupt.
  Assumes an APB master on pclk and same-clock parity and queue signals.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

// Contract
// R1: Report parity error only on flag rise
// R2: Selector 1/2/3 sends COR/NONFATAL/FATAL message
// R3: Selector 0 sends no message
// R4: Eight-bit counter counts each parity error
// R5: Counter saturates at FF, never wraps
// R6: Counter read returns count, then clears
// R7: Enabled time-out discards stale queued packets
// R8: Posted queue discard sets status bit 0
// R9: Non-posted queue discard sets status bit 1
// R10: Completion queue discard sets status bit 2
// R11: Insertion queue discard sets status bit 3
// R12: Parity error sets W1C status flag
// R13: Time-out limit is above 50 ms
// R14: Error during counter read counted after clear
module port_err_regs #(
  parameter int unsigned TIMEOUT_CYCLES = port_err_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Parity checker
  input  wire logic        parity_err_in,
  // Input queues
  input  wire logic [3:0]  head_valid,
  input  wire logic [3:0]  head_taken,
  output logic      [3:0]  discard,
  // Error messages to the root
  output logic             err_msg_valid,
  output logic      [1:0]  err_msg_type,
  // Interrupt
  output logic             irq
);

  port_err_pkg::core_state_type st_q;
  port_err_pkg::core_state_type st_d;

  age_if aif ();

  logic acc_done;
  logic wr;
  logic rd_clr;
  logic [3:0] tmo_kept;
  logic [port_err_pkg::INT_BITS-1:0] int_kept;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  function automatic logic addr_known(input logic [11:0] a);
    case (a)
      port_err_pkg::PERR_STATUS_ADDR,
      port_err_pkg::REPORT_CTL_ADDR,
      port_err_pkg::COUNT_ADDR,
      port_err_pkg::TMO_CTL_ADDR,
      port_err_pkg::TMO_STATUS_ADDR,
      port_err_pkg::INT_MASK_ADDR,
      port_err_pkg::INT_STATUS_ADDR: addr_known = 1'b1;
      default:                       addr_known = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] read_word(input logic [11:0] a,
                                            input port_err_pkg::core_state_type s);
    read_word = 32'h0000_0000;
    case (a)
      port_err_pkg::PERR_STATUS_ADDR: read_word[port_err_pkg::PERR_FLAG_BIT] = s.perr_flag;
      port_err_pkg::REPORT_CTL_ADDR:  read_word[port_err_pkg::REPORT_SEL_LSB +: 2] = s.report_sel;
      port_err_pkg::COUNT_ADDR:       read_word[port_err_pkg::COUNT_LSB +: 8] = s.count;
      port_err_pkg::TMO_CTL_ADDR:     read_word[port_err_pkg::TMO_ENABLE_BIT] = s.tmo_enable;
      port_err_pkg::TMO_STATUS_ADDR:  read_word[port_err_pkg::TMO_FLAG_LSB +: 4] = s.tmo_flag;
      port_err_pkg::INT_MASK_ADDR:    read_word[port_err_pkg::INT_BITS-1:0] = s.int_mask;
      port_err_pkg::INT_STATUS_ADDR:  read_word[port_err_pkg::INT_BITS-1:0] = s.int_status;
      default:                        read_word = 32'h0000_0000;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Age tracker hookup
  // ---------------------------------------------------------------------------
  assign aif.enable     = st_q.tmo_enable;                          // [R7]
  assign aif.head_valid = head_valid;
  assign aif.head_taken = head_taken;

  queue_age_tracker #(
    .LIMIT_CYCLES (TIMEOUT_CYCLES)
  ) u_age (
    .pclk    (pclk),
    .presetn (presetn),
    .aif     (aif.ager)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Read data is captured one cycle ahead of completion so prdata comes from
  // a flop; every write and the read clear act only at the completing edge.
  assign acc_done = psel && penable && (st_q.phase == port_err_pkg::ACC_READY);
  assign wr       = acc_done && pwrite;
  assign rd_clr   = acc_done && !pwrite && (paddr == port_err_pkg::COUNT_ADDR);
  assign tmo_kept = (wr && paddr == port_err_pkg::TMO_STATUS_ADDR) ?
                    (st_q.tmo_flag & ~pwdata[port_err_pkg::TMO_FLAG_LSB +: 4]) : st_q.tmo_flag;
  assign int_kept = (wr && paddr == port_err_pkg::INT_STATUS_ADDR) ?
                    (st_q.int_status & ~pwdata[port_err_pkg::INT_BITS-1:0]) : st_q.int_status;

  always_comb begin
    st_d           = st_q;
    st_d.msg_valid = 1'b0;

    case (st_q.phase)
      port_err_pkg::ACC_WAIT: begin
        if (psel && penable) begin
          st_d.phase   = port_err_pkg::ACC_READY;
          st_d.prdata  = read_word(paddr, st_q);
          st_d.pslverr = !addr_known(paddr);
        end
      end
      port_err_pkg::ACC_READY: begin
        st_d.phase = port_err_pkg::ACC_WAIT;
      end
      default: begin
        st_d.phase = port_err_pkg::ACC_WAIT;
      end
    endcase

    if (wr && paddr == port_err_pkg::REPORT_CTL_ADDR) begin
      st_d.report_sel = pwdata[port_err_pkg::REPORT_SEL_LSB +: 2];
    end
    if (wr && paddr == port_err_pkg::TMO_CTL_ADDR) begin
      st_d.tmo_enable = pwdata[port_err_pkg::TMO_ENABLE_BIT];        // [R7]
    end
    if (wr && paddr == port_err_pkg::INT_MASK_ADDR) begin
      st_d.int_mask = pwdata[port_err_pkg::INT_BITS-1:0];
    end

    // Sticky flags: a set in the clearing cycle wins over the clear
    if (wr && paddr == port_err_pkg::PERR_STATUS_ADDR) begin
      st_d.perr_flag = st_q.perr_flag & ~pwdata[port_err_pkg::PERR_FLAG_BIT];
    end
    if (parity_err_in) begin
      st_d.perr_flag = 1'b1;                                        // [R12]
    end
    st_d.tmo_flag   = tmo_kept | aif.discard;                       // [R8] [R9] [R10] [R11]
    st_d.int_status = int_kept | {aif.discard, parity_err_in};

    // Counts that arrive between capture and clear survive the clear
    if (rd_clr) begin
      st_d.count = st_q.count - st_q.prdata[port_err_pkg::COUNT_LSB +: 8]
                   + {7'h00, parity_err_in};                        // [R6] [R14]
    end else if (parity_err_in && st_q.count != port_err_pkg::COUNT_MAX) begin
      st_d.count = st_q.count + 8'h01;                              // [R4] [R5]
    end

    if (!st_q.perr_flag && st_d.perr_flag &&
        st_q.report_sel != port_err_pkg::REPORT_NONE) begin        // [R1] [R3]
      st_d.msg_valid = 1'b1;
      st_d.msg_type  = st_q.report_sel;                             // [R2]
    end

    st_d.irq = |(st_d.int_status & st_d.int_mask);
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q            <= '0;
      st_q.phase      <= port_err_pkg::ACC_WAIT;
      st_q.report_sel <= port_err_pkg::REPORT_SEL_RESET;
      st_q.count      <= port_err_pkg::COUNT_RESET;
      st_q.tmo_enable <= port_err_pkg::TMO_ENABLE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata        = st_q.prdata;
  assign pready        = st_q.phase[port_err_pkg::ACC_READY_BIT];
  assign pslverr       = st_q.pslverr;
  assign discard       = aif.discard;
  assign err_msg_valid = st_q.msg_valid;
  assign err_msg_type  = st_q.msg_type;
  assign irq           = st_q.irq;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  msg_on_rise_a: assert property (                                   // [R1]
    err_msg_valid |-> $rose(st_q.perr_flag))
    else $error("error message without a parity flag rise");

  msg_code_a: assert property (                                      // [R2]
    ($rose(st_q.perr_flag) && $past(st_q.report_sel) != 2'h0)
    |-> err_msg_valid && err_msg_type == $past(st_q.report_sel))
    else $error("error message missing or of the wrong class");

  silent_none_a: assert property (                                   // [R3]
    ($past(st_q.report_sel) == 2'h0) |-> !err_msg_valid)
    else $error("error message sent with reporting off");

  count_step_a: assert property (                                    // [R4]
    (parity_err_in && !rd_clr && st_q.count != 8'hFF)
    |=> st_q.count == $past(st_q.count) + 8'h01)
    else $error("parity counter missed an increment");

  count_saturate_a: assert property (                                // [R5]
    (st_q.count == 8'hFF && !rd_clr) |=> st_q.count == 8'hFF)
    else $error("parity counter wrapped");

  read_clear_a: assert property (                                    // [R6] [R14]
    (rd_clr && st_q.prdata[7:0] == st_q.count)
    |=> st_q.count == {7'h00, $past(parity_err_in)})
    else $error("counter read did not clear or lost an error");

  read_value_a: assert property (                                    // [R6]
    (psel && penable && !pwrite && !pready && paddr == 12'h74C && !parity_err_in)
    |=> prdata[7:0] == $past(st_q.count) ##1 st_q.count == {7'h00, $past(parity_err_in)})
    else $error("counter read returned a stale count");

  timeout_flag_a: assert property (                                  // [R8] [R9] [R10] [R11]
    (|discard) |=> (st_q.tmo_flag & $past(discard)) == $past(discard))
    else $error("queue discard did not set its status bit");

  parity_flag_a: assert property (                                   // [R12]
    parity_err_in |=> st_q.perr_flag)
    else $error("parity error did not set the status flag");

  irq_level_a: assert property (
    irq == |$past(st_d.int_status & st_d.int_mask))
    else $error("interrupt does not follow unmasked status");

  msg_sent_c: cover property (err_msg_valid && err_msg_type == 2'h3);
  count_full_c: cover property (st_q.count == 8'hFF && parity_err_in);
  read_race_c: cover property (rd_clr && parity_err_in);
  discard_seen_c: cover property (discard[3] && st_q.tmo_enable);

endmodule

`default_nettype wire

// ===== verif/root_msg_model.sv
/*
  Receiving end of the error message link: counts every message the port
  sends and keeps the type of the last one.
  Assumes messages are one-cycle pulses on pclk.
*/
`timescale 1ns/10ps
`default_nettype none

module root_msg_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Messages from the port
  input  wire logic        err_msg_valid,
  input  wire logic [1:0]  err_msg_type,
  // Observed traffic
  output logic      [15:0] msg_count,
  output logic      [1:0]  last_type
);
  // Each valid cycle is one message, so a stretched pulse shows as extras
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_count <= 16'h0000;
      last_type <= 2'h0;
    end else if (err_msg_valid) begin
      msg_count <= msg_count + 16'h0001;
      last_type <= err_msg_type;
    end
  end
endmodule

`default_nettype wire

// ===== verif/port_err_regs_tb.sv
/*
  Self-checking bench for the port error and time-out register bank.
  Assumes the design answers APB with pready and a short time-out limit.
*/
`timescale 1ns/10ps
`default_nettype none

module port_err_regs_tb;
  localparam int TMO = 20;
  logic        pclk, presetn, psel, penable, pwrite, parity_err_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rd2;
  logic        pready, pslverr, err, err_msg_valid, irq;
  logic [3:0]  head_valid, head_taken, discard;
  logic [1:0]  err_msg_type, last_type;
  logic [15:0] msg_count;
  int          num_errors, n_compared, exp_msgs;

  port_err_regs #(.TIMEOUT_CYCLES(TMO)) port_err_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .parity_err_in(parity_err_in),
    .head_valid(head_valid), .head_taken(head_taken), .discard(discard),
    .err_msg_valid(err_msg_valid), .err_msg_type(err_msg_type), .irq(irq)
  );

  root_msg_model root_msg_model_inst (
    .pclk(pclk), .presetn(presetn), .err_msg_valid(err_msg_valid),
    .err_msg_type(err_msg_type), .msg_count(msg_count), .last_type(last_type)
  );

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Holds the whole request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) chk("pready wait", 32'h1, 32'h0);
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask

  // Parity error held for n cycles counts as n errors
  task automatic perr(input int n);
    @(posedge pclk);
    parity_err_in <= 1'b1;
    repeat (n) @(posedge pclk);
    parity_err_in <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic msgchk(input logic [1:0] typ);
    chk("message count", 32'(exp_msgs), {16'h0000, msg_count});
    chk("message type", {30'h0, typ}, {30'h0, last_type});
  endtask

  // Cycles from head arrival to the discard pulse; 60 means none came
  task automatic age(input int i, input int exp_k);
    int k;
    k = 0;
    @(posedge pclk);
    head_valid[i] <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (discard[i] !== 1'b1 && k < 60);
    head_valid[i] <= 1'b0;
    chk("discard delay", 32'(exp_k), 32'(k));
  endtask

  // ---------------------------------------------------------------------------
  // Clock, reset, watchdog
  // ---------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #200us;
    num_errors++;
    close_out();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    parity_err_in = 1'b0;
    head_valid = 4'h0;
    head_taken = 4'h0;
    num_errors = 0;
    n_compared = 0;
    exp_msgs = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("report ctl reset", port_err_pkg::REPORT_CTL_ADDR, 32'h0000_0002);
    rdchk("count reset", port_err_pkg::COUNT_ADDR, 32'h0000_0000);
    rdchk("tmo ctl reset", port_err_pkg::TMO_CTL_ADDR, 32'h0000_0001);
    rdchk("tmo status reset", port_err_pkg::TMO_STATUS_ADDR, 32'h0000_0000);
    apb(1'b1, 12'h700, 32'hFFFF_FFFF);
    chk("unmapped error", 32'h1, {31'h0, err});
    // First error reports, a second one while the flag is set does not
    perr(1);
    exp_msgs++;
    msgchk(2'h2);
    perr(1);
    msgchk(2'h2);
    rdchk("flag set", port_err_pkg::PERR_STATUS_ADDR, 32'h0000_0001);
    rdchk("count two", port_err_pkg::COUNT_ADDR, 32'h0000_0002);
    rdchk("count cleared", port_err_pkg::COUNT_ADDR, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, port_err_pkg::PERR_STATUS_ADDR, 32'h0000_0001);
      rdchk("flag cleared", port_err_pkg::PERR_STATUS_ADDR, 32'h0000_0000);
      apb(1'b1, port_err_pkg::REPORT_CTL_ADDR, 32'(s));
      perr(1);
      if (s != 0) exp_msgs++;
      msgchk((s == 0) ? 2'h2 : 2'(s));
    end
    perr(300);
    rdchk("count saturated", port_err_pkg::COUNT_ADDR, 32'h0000_00FF);
    rdchk("count after clear", port_err_pkg::COUNT_ADDR, 32'h0000_0000);
    // Error lands in the completion cycle of the clearing read
    fork
      apb(1'b0, port_err_pkg::COUNT_ADDR, 32'h0000_0000);
      begin
        repeat (3) @(posedge pclk);
        parity_err_in <= 1'b1;
        @(posedge pclk);
        parity_err_in <= 1'b0;
      end
    join
    rd2 = rd;
    apb(1'b0, port_err_pkg::COUNT_ADDR, 32'h0000_0000);
    chk("error kept across clear", 32'h1, rd2 + rd);
    for (int i = 0; i < 4; i++) age(i, TMO + 2);
    rdchk("tmo flags", port_err_pkg::TMO_STATUS_ADDR, 32'h0000_000F);
    apb(1'b1, port_err_pkg::TMO_STATUS_ADDR, 32'h0000_0005);
    rdchk("tmo w1c", port_err_pkg::TMO_STATUS_ADDR, 32'h0000_000A);
    apb(1'b1, port_err_pkg::TMO_STATUS_ADDR, 32'h0000_000A);
    rdchk("tmo cleared", port_err_pkg::TMO_STATUS_ADDR, 32'h0000_0000);
    apb(1'b1, port_err_pkg::TMO_CTL_ADDR, 32'h0000_0000);
    age(2, 60);
    rdchk("no discard flag", port_err_pkg::TMO_STATUS_ADDR, 32'h0000_0000);
    // A head that keeps leaving normally never ages out
    apb(1'b1, port_err_pkg::TMO_CTL_ADDR, 32'h0000_0001);
    head_taken <= 4'h2;
    age(1, 60);
    head_taken <= 4'h0;
    // Interrupt: raised by an unmasked bit, gone when that bit is cleared
    rdchk("int status", port_err_pkg::INT_STATUS_ADDR, 32'h0000_001F);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, port_err_pkg::INT_MASK_ADDR, 32'h0000_0002);
    @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, port_err_pkg::INT_STATUS_ADDR, 32'h0000_0002);
    @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdchk("int status left", port_err_pkg::INT_STATUS_ADDR, 32'h0000_001D);
    close_out();
  end
endmodule

`default_nettype wire
